//--- hdl/pxc_ext_cap_map.sv
// pxc_ext_cap_map: extended configuration space of one switch port,
// byte offsets 100h-23Fh, with the linked capability header chain.
// assumes a config master with one-cycle read/write strobes; read data
// appear the cycle after the read strobe and only then.
//
// Functional notes
// - first extended capability header sits at byte offset 100h
// - every further capability lies above 0FFh; lower offsets not ours
// - error reporting, virtual channel and power budget structures exist
// - header at 100h reads ID 0001h, next pointer 140h
// - header at 20Ch reads ID 0004h, next pointer 220h or 230h
// - header at 220h reads ID 000Dh, next pointer 000h ends chain
// - virtual channel arbitration table holds 32 phases
// - port arbitration tables of 128 phases for VC0 and VC1 (180h-1FCh)
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

module pxc_ext_cap_map
  import pxc_pkg::*;
#(
  parameter logic [3:0]  CAP_VER     = 4'h1,
  parameter logic [31:0] PVC_CAP1    = 32'h0000_0001,
  parameter logic [31:0] PVC_CAP2    = 32'h0000_0001,
  parameter logic [31:0] VC0_CAP     = 32'h0000_0001,
  parameter logic [31:0] VC1_CAP     = 32'h0000_0001,
  parameter logic [31:0] PB_CAP      = 32'h0000_0001,
  parameter logic [31:0] ACS_CAP     = 32'h0000_001f,
  parameter int          PB_ENTRIES  = 4,
  parameter logic [31:0] PB_VALUE    = 32'h0000_0000
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // configuration register port
  input  wire logic [ADDR_W-1:0] cfg_addr,
  input  wire logic [DATA_W-1:0] cfg_wdata,
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  output logic      [DATA_W-1:0] cfg_rdata,
  // error events from the port
  input  wire logic [31:0]       unc_err_set,
  input  wire logic [31:0]       cor_err_set,
  input  wire logic [127:0]      unc_hdr_in,
  // control state toward the port
  output logic      [31:0]       unc_mask,
  output logic      [31:0]       unc_severity,
  output logic      [31:0]       cor_mask,
  output logic      [31:0]       vc0_ctrl,
  output logic      [31:0]       vc1_ctrl,
  output logic      [31:0]       egress_vec,
  output logic      [31:0]       max_snoop_lat
);

  localparam int VCARB_WORDS = VCARB_PHASES * PHASE_BITS / DATA_W;
  localparam int PARB_WORDS  = PARB_PHASES * PHASE_BITS / DATA_W;

  // header words: next[31:20] version[19:16] id[15:0]
  localparam logic [31:0] HDR_AER = {OFF_VC_HDR, CAP_VER, ID_AER};
  localparam logic [31:0] HDR_VC  = {OFF_PB_HDR, CAP_VER, ID_VC};
  localparam logic [31:0] HDR_ACS = {OFF_CHAIN_END, CAP_VER, ID_ACS};
  localparam logic [31:0] HDR_LTR = {OFF_CHAIN_END, CAP_VER, ID_LTR};

  // register state
  logic [31:0] unc_stat_q,  cor_stat_q;
  logic [31:0] unc_mask_q,  unc_sev_q,   cor_mask_q;
  logic [31:0] aer_ctrl_q,  pvc_ctrl_q,  vc0_ctrl_q,  vc1_ctrl_q;
  logic [31:0] pb_sel_q,    acs_ctrl_q,  egress_q,    max_snp_q;
  logic [31:0] chain_sel_q;
  logic [31:0] hlog_q [4];
  logic [31:0] vcarb_q [VCARB_WORDS];
  logic [31:0] parb0_q [PARB_WORDS];
  logic [31:0] parb1_q [PARB_WORDS];
  logic [31:0] rdata_q, rdata_d;
  logic [11:0] waddr;
  logic        in_vcarb, in_parb0, in_parb1, in_hlog;
  logic [31:0] unc_new;
  logic [FEP_W-1:0] first_err;
  logic [11:0] pb_next;

  // dword address; byte lanes below bit 2 do not matter
  assign waddr = {cfg_addr[11:2], 2'b00};

  // table windows, fixed by the low and high window offsets in the package
  assign in_vcarb = (waddr >= OFF_VCARB_LO) && (waddr <= OFF_VCARB_HI);
  assign in_parb0 = (waddr >= OFF_PARB0_LO) && (waddr <= OFF_PARB0_HI);
  assign in_parb1 = (waddr >= OFF_PARB1_LO) && (waddr <= OFF_PARB1_HI);
  assign in_hlog  = (waddr >= OFF_HLOG_LO) && (waddr <= OFF_HLOG_HI);

  // power budget link: software choice decides whether LTR follows
  assign pb_next = chain_sel_q[0] ? OFF_LTR_HDR : OFF_ACS_HDR;

  // write helper: keep read-only bits, take writable ones
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] wm);
    merge = (old & ~wm) | (wd & wm);
  endfunction : merge

  // lowest newly set unmasked error, for the first error pointer
  always_comb begin
    first_err = '0;
    for (int i = 31; i >= 0; i--) begin
      if (unc_new[i]) begin
        first_err = i[FEP_W-1:0];
      end
    end
  end

  // only unmasked events may claim the header log
  assign unc_new = unc_err_set & ~unc_mask_q;

  // error status bits: hardware set beats a same-cycle write-1-to-clear
  always_ff @(posedge clk) begin
    if (reset) begin
      unc_stat_q <= RST_ZERO;
      cor_stat_q <= RST_ZERO;
    end else begin
      unc_stat_q <= (unc_stat_q &
                     ~((cfg_wr && waddr == OFF_UNC_STAT) ? cfg_wdata : '0))
                    | unc_err_set;
      cor_stat_q <= (cor_stat_q &
                     ~((cfg_wr && waddr == OFF_COR_STAT) ? cfg_wdata : '0))
                    | cor_err_set;
    end
  end

  // header log and first error pointer: caught only when log is free
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        hlog_q[i] <= RST_ZERO;
      end
      aer_ctrl_q <= RST_ZERO;
    end else begin
      if (cfg_wr && waddr == OFF_AER_CTRL) begin
        aer_ctrl_q <= merge(aer_ctrl_q, cfg_wdata, WM_AER_CTRL);
      end
      if ((unc_new != '0) && ((unc_stat_q & ~unc_mask_q) == '0)) begin
        for (int i = 0; i < 4; i++) begin
          hlog_q[i] <= unc_hdr_in[32*i +: 32];
        end
        aer_ctrl_q[FEP_LSB +: FEP_W] <= first_err;
      end
    end
  end

  // error masks and severity
  always_ff @(posedge clk) begin
    if (reset) begin
      unc_mask_q <= RST_ZERO;
      unc_sev_q  <= RST_ZERO;
      cor_mask_q <= RST_ZERO;
    end else if (cfg_wr) begin
      if (waddr == OFF_UNC_MASK) unc_mask_q <= cfg_wdata;
      if (waddr == OFF_UNC_SEV)  unc_sev_q  <= cfg_wdata;
      if (waddr == OFF_COR_MASK) cor_mask_q <= cfg_wdata;
    end
  end

  // virtual channel control words
  always_ff @(posedge clk) begin
    if (reset) begin
      pvc_ctrl_q <= RST_ZERO;
      vc0_ctrl_q <= RST_VC0_CTRL;
      vc1_ctrl_q <= RST_ZERO;
    end else if (cfg_wr) begin
      if (waddr == OFF_PVC_CTRL)
        pvc_ctrl_q <= merge(pvc_ctrl_q, cfg_wdata, WM_PVC_CTRL);
      if (waddr == OFF_VC0_CTRL)
        vc0_ctrl_q <= merge(vc0_ctrl_q, cfg_wdata, WM_VC0_CTRL);
      if (waddr == OFF_VC1_CTRL)
        vc1_ctrl_q <= merge(vc1_ctrl_q, cfg_wdata, WM_VC1_CTRL);
    end
  end

  // arbitration tables; no reset, software loads them before enabling
  always_ff @(posedge clk) begin
    if (cfg_wr && in_vcarb) begin
      vcarb_q[waddr[3:2]] <= cfg_wdata;
    end
    if (cfg_wr && in_parb0) begin
      parb0_q[waddr[5:2]] <= cfg_wdata;
    end
    if (cfg_wr && in_parb1) begin
      parb1_q[waddr[5:2]] <= cfg_wdata;
    end
  end

  // power budget, access control, latency and chain selection
  always_ff @(posedge clk) begin
    if (reset) begin
      pb_sel_q    <= RST_ZERO;
      acs_ctrl_q  <= RST_ZERO;
      egress_q    <= RST_ZERO;
      max_snp_q   <= RST_ZERO;
      chain_sel_q <= RST_ZERO;
    end else if (cfg_wr) begin
      if (waddr == OFF_PB_SEL)
        pb_sel_q <= merge(pb_sel_q, cfg_wdata, WM_PB_SEL);
      if (waddr == OFF_ACS_CTRL)
        acs_ctrl_q <= merge(acs_ctrl_q, cfg_wdata, WM_ACS_CTRL);
      if (waddr == OFF_EGRESS)
        egress_q <= merge(egress_q, cfg_wdata, WM_EGRESS);
      if (waddr == OFF_MAX_SNP)
        max_snp_q <= merge(max_snp_q, cfg_wdata, WM_MAX_SNP);
      if (waddr == OFF_CHAIN_SEL)
        chain_sel_q <= merge(chain_sel_q, cfg_wdata, WM_CHAIN_SEL);
    end
  end

  // read decode; reserved holes and offsets below 100h read as zero
  always_comb begin
    rdata_d = RST_ZERO;
    if (waddr < OFF_EXT_BASE) begin
      rdata_d = RST_ZERO;
    end else if (in_hlog) begin
      rdata_d = hlog_q[waddr[3:2] - OFF_HLOG_LO[3:2]];
    end else if (in_vcarb) begin
      rdata_d = vcarb_q[waddr[3:2]];
    end else if (in_parb0) begin
      rdata_d = parb0_q[waddr[5:2]];
    end else if (in_parb1) begin
      rdata_d = parb1_q[waddr[5:2]];
    end else begin
      case (waddr)
        OFF_AER_HDR:   rdata_d = HDR_AER;
        OFF_UNC_STAT:  rdata_d = unc_stat_q;
        OFF_UNC_MASK:  rdata_d = unc_mask_q;
        OFF_UNC_SEV:   rdata_d = unc_sev_q;
        OFF_COR_STAT:  rdata_d = cor_stat_q;
        OFF_COR_MASK:  rdata_d = cor_mask_q;
        OFF_AER_CTRL:  rdata_d = aer_ctrl_q;
        OFF_VC_HDR:    rdata_d = HDR_VC;
        OFF_PVC_CAP1:  rdata_d = PVC_CAP1;
        OFF_PVC_CAP2:  rdata_d = {VCARB_QW_OFF, PVC_CAP2[23:0]};
        OFF_PVC_CTRL:  rdata_d = pvc_ctrl_q;
        OFF_VC0_CAP:   rdata_d = {PARB0_QW_OFF, VC0_CAP[23:0]};
        OFF_VC0_CTRL:  rdata_d = vc0_ctrl_q;
        OFF_VC0_STAT:  rdata_d = RST_ZERO;
        OFF_VC1_CAP:   rdata_d = {PARB1_QW_OFF, VC1_CAP[23:0]};
        OFF_VC1_CTRL:  rdata_d = vc1_ctrl_q;
        OFF_VC1_STAT:  rdata_d = RST_ZERO;
        OFF_PB_HDR:    rdata_d = {pb_next, CAP_VER, ID_PB};
        OFF_PB_SEL:    rdata_d = pb_sel_q;
        // data select past the table end reads zero
        OFF_PB_DATA:   rdata_d = (pb_sel_q < PB_ENTRIES) ? PB_VALUE : RST_ZERO;
        OFF_PB_CAP:    rdata_d = PB_CAP;
        OFF_ACS_HDR:   rdata_d = HDR_ACS;
        OFF_ACS_CTRL:  rdata_d = acs_ctrl_q | ACS_CAP;
        OFF_EGRESS:    rdata_d = egress_q;
        OFF_LTR_HDR:   rdata_d = HDR_LTR;
        OFF_MAX_SNP:   rdata_d = max_snp_q;
        OFF_CHAIN_SEL: rdata_d = chain_sel_q;
        default:       rdata_d = RST_ZERO;
      endcase
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= RST_ZERO;
    end else begin
      rdata_q <= cfg_rd ? rdata_d : RST_ZERO;
    end
  end

  // outputs straight from flops
  assign cfg_rdata     = rdata_q;
  assign unc_mask      = unc_mask_q;
  assign unc_severity  = unc_sev_q;
  assign cor_mask      = cor_mask_q;
  assign vc0_ctrl      = vc0_ctrl_q;
  assign vc1_ctrl      = vc1_ctrl_q;
  assign egress_vec    = egress_q;
  assign max_snoop_lat = max_snp_q;

  // checks on the capability chain and register behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_aer_hdr_read: assert property (
    cfg_rd && waddr == OFF_AER_HDR |=> cfg_rdata[31:20] == 12'h140
      && cfg_rdata[15:0] == 16'h0001)
    else $error("error reporting header wrong");

  a_vc_hdr_read: assert property (
    cfg_rd && waddr == OFF_VC_HDR |=> cfg_rdata[31:20] == 12'h20c
      && cfg_rdata[15:0] == 16'h0002)
    else $error("virtual channel header wrong");

  a_pb_next_ptr: assert property (
    cfg_rd && waddr == OFF_PB_HDR |=> cfg_rdata[15:0] == 16'h0004
      && cfg_rdata[31:20] == ($past(chain_sel_q[0]) ? 12'h230 : 12'h220))
    else $error("power budget next pointer wrong");

  a_acs_chain_end: assert property (
    cfg_rd && waddr == OFF_ACS_HDR |=> cfg_rdata == {12'h000, CAP_VER,
      16'h000d})
    else $error("access control header wrong");

  a_ltr_chain_end: assert property (
    cfg_rd && waddr == OFF_LTR_HDR |=> cfg_rdata[31:20] == 12'h000
      && cfg_rdata[15:0] == 16'h0018)
    else $error("latency header wrong");

  a_low_space_zero: assert property (
    cfg_rd && cfg_addr < 12'h100 |=> cfg_rdata == 32'h0)
    else $error("offset below 100h answered");

  a_vc_arb_hold: assert property (
    cfg_wr && in_vcarb ##1 cfg_rd && cfg_addr == $past(cfg_addr)
      |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("vc arbitration word lost");

  a_port_arb1_hold: assert property (
    cfg_wr && in_parb1 ##1 cfg_rd && cfg_addr == $past(cfg_addr)
      |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("vc1 port arbitration word lost");

  a_status_set_wins: assert property (
    unc_err_set != '0 |=> (unc_stat_q & $past(unc_err_set))
      == $past(unc_err_set))
    else $error("error status bit not set");

  // a clear that meets a new event in one cycle must not eat the event
  a_clear_race: assert property (
    cfg_wr && waddr == OFF_UNC_STAT && (cfg_wdata & unc_err_set) != '0
      |=> (unc_stat_q & $past(unc_err_set)) == $past(unc_err_set))
    else $error("same-cycle clear beat the error event");

  a_port_arb0_hold: assert property (
    cfg_wr && in_parb0 ##1 cfg_rd && cfg_addr == $past(cfg_addr)
      |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("vc0 port arbitration word lost");

  // the log belongs to the first error until software clears it
  a_hlog_frozen: assert property (
    (unc_stat_q & ~unc_mask_q) != '0 |=> $stable(hlog_q[0])
      && $stable(aer_ctrl_q[FEP_LSB +: FEP_W]))
    else $error("header log overwritten while in use");

  // read-only bits of channel control must shrug off writes
  a_vc0_ro_bits: assert property (
    cfg_wr && waddr == OFF_VC0_CTRL |=> (vc0_ctrl & ~WM_VC0_CTRL)
      == ($past(vc0_ctrl) & ~WM_VC0_CTRL))
    else $error("read-only channel control bits changed");

  // the mask reaches the port the edge after the write
  a_mask_copy: assert property (
    cfg_wr && waddr == OFF_UNC_MASK |=> unc_mask == $past(cfg_wdata))
    else $error("uncorrectable mask not taken");

  // software finds the arbitration table through this offset field
  a_vc_cap2_offset: assert property (
    cfg_rd && waddr == OFF_PVC_CAP2 |=> cfg_rdata[31:24] == 8'h03)
    else $error("vc arbitration table offset wrong");

  // a data select past the table end must read as zero
  a_pb_data_range: assert property (
    cfg_rd && waddr == OFF_PB_DATA && pb_sel_q >= PB_ENTRIES
      |=> cfg_rdata == 32'h0)
    else $error("power budget data beyond table end");

  a_read_only_once: assert property (
    !cfg_rd |=> cfg_rdata == 32'h0)
    else $error("read data outside its cycle");

  c_walk_aer: cover property (
    cfg_rd && waddr == OFF_AER_HDR ##1 cfg_rd && waddr == OFF_VC_HDR);
  c_chain_ltr: cover property (
    cfg_rd && waddr == OFF_PB_HDR && chain_sel_q[0]);
  c_parb0_write: cover property (cfg_wr && in_parb0);
  c_hdr_capture: cover property (unc_new != '0 && unc_stat_q == '0);
  c_set_beats_clear: cover property (
    cfg_wr && waddr == OFF_UNC_STAT && unc_err_set != '0);

endmodule : pxc_ext_cap_map

//--- hdl/pxc_pkg.sv
// pxc_pkg: offsets, header codes, write masks and reset values of the
// extended configuration space map (byte offsets 100h and up).
// assumes a 12-bit configuration byte address and 32-bit dword access.
package pxc_pkg;

  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;

  // capability structure offsets and header codes
  localparam logic [11:0] OFF_EXT_BASE = 12'h100;
  localparam logic [11:0] OFF_AER_HDR  = 12'h100;
  localparam logic [11:0] OFF_VC_HDR   = 12'h140;
  localparam logic [11:0] OFF_PB_HDR   = 12'h20c;
  localparam logic [11:0] OFF_ACS_HDR  = 12'h220;
  localparam logic [11:0] OFF_LTR_HDR  = 12'h230;
  localparam logic [11:0] OFF_CHAIN_END = 12'h000;
  localparam logic [15:0] ID_AER       = 16'h0001;
  localparam logic [15:0] ID_VC        = 16'h0002;
  localparam logic [15:0] ID_PB        = 16'h0004;
  localparam logic [15:0] ID_ACS       = 16'h000d;
  localparam logic [15:0] ID_LTR       = 16'h0018;

  // error reporting registers
  localparam logic [11:0] OFF_UNC_STAT = 12'h104;
  localparam logic [11:0] OFF_UNC_MASK = 12'h108;
  localparam logic [11:0] OFF_UNC_SEV  = 12'h10c;
  localparam logic [11:0] OFF_COR_STAT = 12'h110;
  localparam logic [11:0] OFF_COR_MASK = 12'h114;
  localparam logic [11:0] OFF_AER_CTRL = 12'h118;
  localparam logic [11:0] OFF_HLOG_LO  = 12'h11c;
  localparam logic [11:0] OFF_HLOG_HI  = 12'h128;

  // virtual channel registers and tables
  localparam logic [11:0] OFF_PVC_CAP1 = 12'h144;
  localparam logic [11:0] OFF_PVC_CAP2 = 12'h148;
  localparam logic [11:0] OFF_PVC_CTRL = 12'h14c;
  localparam logic [11:0] OFF_VC0_CAP  = 12'h150;
  localparam logic [11:0] OFF_VC0_CTRL = 12'h154;
  localparam logic [11:0] OFF_VC0_STAT = 12'h158;
  localparam logic [11:0] OFF_VC1_CAP  = 12'h15c;
  localparam logic [11:0] OFF_VC1_CTRL = 12'h160;
  localparam logic [11:0] OFF_VC1_STAT = 12'h164;
  localparam logic [11:0] OFF_VCARB_LO = 12'h170;
  localparam logic [11:0] OFF_VCARB_HI = 12'h17c;
  localparam logic [11:0] OFF_PARB0_LO = 12'h180;
  localparam logic [11:0] OFF_PARB0_HI = 12'h1bc;
  localparam logic [11:0] OFF_PARB1_LO = 12'h1c0;
  localparam logic [11:0] OFF_PARB1_HI = 12'h1fc;
  localparam logic [7:0]  VCARB_QW_OFF = 8'h03; // table offsets, 16-byte units
  localparam logic [7:0]  PARB0_QW_OFF = 8'h04;
  localparam logic [7:0]  PARB1_QW_OFF = 8'h06;
  localparam int          VCARB_PHASES = 32;
  localparam int          PARB_PHASES  = 128;
  localparam int          PHASE_BITS   = 4;

  // power budgeting, access control, latency tolerance
  localparam logic [11:0] OFF_PB_SEL   = 12'h210;
  localparam logic [11:0] OFF_PB_DATA  = 12'h214;
  localparam logic [11:0] OFF_PB_CAP   = 12'h218;
  localparam logic [11:0] OFF_ACS_CTRL = 12'h224;
  localparam logic [11:0] OFF_EGRESS   = 12'h228;
  localparam logic [11:0] OFF_MAX_SNP  = 12'h234;
  localparam logic [11:0] OFF_CHAIN_SEL = 12'h238;

  // software-writable bits and reset values
  localparam logic [31:0] WM_AER_CTRL  = 32'h0000_0140;
  localparam logic [31:0] WM_PVC_CTRL  = 32'h0000_000f;
  localparam logic [31:0] WM_VC0_CTRL  = 32'h070f_00fe;
  localparam logic [31:0] WM_VC1_CTRL  = 32'h870f_00fe;
  localparam logic [31:0] WM_PB_SEL    = 32'h0000_00ff;
  localparam logic [31:0] WM_ACS_CTRL  = 32'h007f_0000;
  localparam logic [31:0] WM_EGRESS    = 32'h0000_0007;
  localparam logic [31:0] WM_MAX_SNP   = 32'h1fff_1fff;
  localparam logic [31:0] WM_CHAIN_SEL = 32'h0000_0001;
  localparam logic [31:0] RST_VC0_CTRL = 32'h8000_00ff;
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  localparam int          FEP_LSB      = 0;   // first error pointer field
  localparam int          FEP_W        = 5;

endpackage : pxc_pkg

//--- tb/pxc_rc_model.sv
// pxc_rc_model: configuration master standing in for the root complex.
// assumes the map samples strobes on the rising edge of clk and answers
// a read in the one cycle after the strobe.
`timescale 1ns/1ps

module pxc_rc_model (
  // clock
  input  wire logic        clk,
  // configuration request port
  output logic      [11:0] cfg_addr,
  output logic      [31:0] cfg_wdata,
  output logic             cfg_wr,
  output logic             cfg_rd,
  input  wire logic [31:0] cfg_rdata
);

  // quiet bus from time zero
  initial begin
    cfg_addr  = 12'h000;
    cfg_wdata = 32'h0000_0000;
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
  end

  // write strobe stays up until the next request or idle, so a read
  // may follow with no gap
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    cfg_rd    <= 1'b0;
    cfg_addr  <= a;
    cfg_wdata <= d;
  endtask : wr

  // read; data caught in the single cycle they stand
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    cfg_rd    <= 1'b1;
    cfg_wr    <= 1'b0;
    cfg_addr  <= a;
    cfg_wdata <= ~cfg_wdata; // released data never keeps a stale value
    @(posedge clk);
    cfg_rd    <= 1'b0;
    cfg_addr  <= ~a;
    #1 d = cfg_rdata;
  endtask : rd

  // drop any held strobe
  task automatic idle();
    @(posedge clk);
    cfg_wr    <= 1'b0;
    cfg_rd    <= 1'b0;
    cfg_wdata <= ~cfg_wdata;
  endtask : idle

endmodule : pxc_rc_model

//--- tb/tb_pcie_extended_cap_space_map.sv
// tb_pcie_extended_cap_space_map: self-checking bench of the map.
// assumes the root complex model drives the config port; error events
// and the header log input come from here.
`timescale 1ns/1ps

module tb_pcie_extended_cap_space_map;
  import pxc_pkg::*;

  typedef struct packed {
    logic [11:0] a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
  } pxc_row_t;

  logic          clk;
  logic          reset;
  logic [11:0]   cfg_addr;
  logic [31:0]   cfg_wdata;
  logic          cfg_wr;
  logic          cfg_rd;
  logic [31:0]   cfg_rdata;
  logic [31:0]   unc_err_set;
  logic [31:0]   cor_err_set;
  logic [127:0]  unc_hdr_in;
  logic [31:0]   unc_mask;
  logic [31:0]   unc_severity;
  logic [31:0]   cor_mask;
  logic [31:0]   vc0_ctrl;
  logic [31:0]   vc1_ctrl;
  logic [31:0]   egress_vec;
  logic [31:0]   max_snoop_lat;
  logic [31:0]   got;
  int            failures;
  int            num_checks;

  // ordinary cases: read-only words, holes, table and control writes
  pxc_row_t rows [30] = '{
    '{OFF_AER_HDR, 1'b0, 32'h0, {OFF_VC_HDR, 4'h1, ID_AER}},
    '{OFF_AER_HDR, 1'b1, '1, {OFF_VC_HDR, 4'h1, ID_AER}},
    '{OFF_VC_HDR, 1'b0, 32'h0, {OFF_PB_HDR, 4'h1, ID_VC}},
    '{OFF_PB_HDR, 1'b0, 32'h0, {OFF_ACS_HDR, 4'h1, ID_PB}},
    '{OFF_ACS_HDR, 1'b0, 32'h0, {OFF_CHAIN_END, 4'h1, ID_ACS}},
    '{OFF_LTR_HDR, 1'b0, 32'h0, {OFF_CHAIN_END, 4'h1, ID_LTR}},
    '{12'h0fc, 1'b0, 32'h0, 32'h0},
    '{12'h040, 1'b1, '1, 32'h0},
    '{12'h12c, 1'b0, 32'h0, 32'h0},
    '{12'h23c, 1'b1, '1, 32'h0},
    '{OFF_PVC_CAP2, 1'b0, 32'h0, 32'h0300_0001},
    '{OFF_VC0_CAP, 1'b0, 32'h0, 32'h0400_0001},
    '{OFF_VC1_CAP, 1'b0, 32'h0, 32'h0600_0001},
    '{OFF_VCARB_LO, 1'b1, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
    '{OFF_VCARB_HI, 1'b1, 32'h1234_5678, 32'h1234_5678},
    '{OFF_PARB0_LO, 1'b1, 32'h8765_4321, 32'h8765_4321},
    '{OFF_PARB0_HI, 1'b1, 32'h0f1e_2d3c, 32'h0f1e_2d3c},
    '{OFF_PARB1_LO, 1'b1, 32'hc3d2_e1f0, 32'hc3d2_e1f0},
    '{OFF_PARB1_HI, 1'b1, 32'h5a69_7887, 32'h5a69_7887},
    '{OFF_PARB0_LO, 1'b0, 32'h0, 32'h8765_4321},
    '{OFF_VC0_CTRL, 1'b1, '1, RST_VC0_CTRL | WM_VC0_CTRL},
    '{OFF_PVC_CTRL, 1'b1, '1, WM_PVC_CTRL},
    '{OFF_EGRESS, 1'b1, '1, WM_EGRESS},
    '{OFF_MAX_SNP, 1'b1, '1, WM_MAX_SNP},
    '{OFF_UNC_MASK, 1'b1, 32'h0000_0010, 32'h0000_0010},
    '{OFF_UNC_SEV, 1'b1, 32'h0006_2030, 32'h0006_2030},
    '{OFF_COR_MASK, 1'b1, 32'h0000_2000, 32'h0000_2000},
    '{OFF_VC1_CTRL, 1'b1, '1, WM_VC1_CTRL},
    '{OFF_PB_SEL, 1'b1, 32'h0000_0010, 32'h0000_0010},
    '{OFF_PB_DATA, 1'b0, 32'h0, 32'h0}
  };

  pxc_ext_cap_map i_dut (
    .clk           (clk),
    .reset         (reset),
    .cfg_addr      (cfg_addr),
    .cfg_wdata     (cfg_wdata),
    .cfg_wr        (cfg_wr),
    .cfg_rd        (cfg_rd),
    .cfg_rdata     (cfg_rdata),
    .unc_err_set   (unc_err_set),
    .cor_err_set   (cor_err_set),
    .unc_hdr_in    (unc_hdr_in),
    .unc_mask      (unc_mask),
    .unc_severity  (unc_severity),
    .cor_mask      (cor_mask),
    .vc0_ctrl      (vc0_ctrl),
    .vc1_ctrl      (vc1_ctrl),
    .egress_vec    (egress_vec),
    .max_snoop_lat (max_snoop_lat)
  );

  pxc_rc_model i_rc (
    .clk       (clk),
    .cfg_addr  (cfg_addr),
    .cfg_wdata (cfg_wdata),
    .cfg_wr    (cfg_wr),
    .cfg_rd    (cfg_rd),
    .cfg_rdata (cfg_rdata)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // fire one cycle of error events
  task automatic pulse(input logic [31:0] u, input logic [31:0] c);
    @(posedge clk);
    unc_err_set <= u;
    cor_err_set <= c;
    @(posedge clk);
    unc_err_set <= 32'h0;
    cor_err_set <= 32'h0;
  endtask : pulse

  // hang guard, far beyond the roughly 140 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial begin
    failures    = 0;
    num_checks  = 0;
    reset       = 1'b1;
    unc_err_set = 32'h0;
    cor_err_set = 32'h0;
    unc_hdr_in  = {32'h4444_4444, 32'h3333_3333, 32'h2222_2222,
                   32'h1111_1111};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("vc0_ctrl reset", RST_VC0_CTRL, vc0_ctrl);
    chk("egress reset", RST_ZERO, egress_vec);
    chk("rdata idle", RST_ZERO, cfg_rdata);
    // each write row is read back at once, no gap after the strobe
    foreach (rows[i]) begin
      if (rows[i].w) begin
        i_rc.wr(rows[i].a, rows[i].d);
      end
      i_rc.rd(rows[i].a, got);
      chk($sformatf("row %0d", i), rows[i].e, got);
    end
    chk("egress port", WM_EGRESS, egress_vec);
    chk("unc_mask port", 32'h0000_0010, unc_mask);
    chk("unc_sev port", 32'h0006_2030, unc_severity);
    chk("cor_mask port", 32'h0000_2000, cor_mask);
    chk("vc1_ctrl port", WM_VC1_CTRL, vc1_ctrl);
    chk("snoop port", WM_MAX_SNP, max_snoop_lat);
    @(posedge clk);
    #1 chk("rdata stands once", RST_ZERO, cfg_rdata);
    // second tail of the chain
    i_rc.wr(OFF_CHAIN_SEL, 32'h1);
    i_rc.rd(OFF_PB_HDR, got);
    chk("pb next ltr", {OFF_LTR_HDR, 4'h1, ID_PB}, got);
    // error log: first unmasked event captures, a later one must not
    pulse(32'h0000_0008, 32'h0000_0004);
    unc_hdr_in <= '1;
    pulse(32'h0000_0020, 32'h0);
    i_rc.rd(OFF_UNC_STAT, got);
    chk("unc status", 32'h0000_0028, got);
    i_rc.rd(OFF_COR_STAT, got);
    chk("cor status", 32'h0000_0004, got);
    i_rc.rd(OFF_AER_CTRL, got);
    chk("first err ptr", 32'd3, got[FEP_LSB +: FEP_W]);
    for (int k = 0; k < 4; k++) begin
      i_rc.rd(OFF_HLOG_LO + 12'(4 * k), got);
      chk("hdr log", 32'h1111_1111 * (k + 1), got);
    end
    i_rc.wr(OFF_UNC_STAT, 32'h0000_0028);
    i_rc.wr(OFF_COR_STAT, 32'h0000_0004);
    i_rc.rd(OFF_UNC_STAT, got);
    chk("unc cleared", RST_ZERO, got);
    i_rc.rd(OFF_COR_STAT, got);
    chk("cor cleared", RST_ZERO, got);
    // event and clear of the same bit in one cycle: the event wins
    i_rc.wr(OFF_UNC_STAT, 32'h0000_0008);
    unc_err_set <= 32'h0000_0008;
    i_rc.idle();
    unc_err_set <= 32'h0;
    i_rc.rd(OFF_UNC_STAT, got);
    chk("set beats clear", 32'h0000_0008, got);
    // reset in mid-run brings control state and chain select back
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("vc0_ctrl rerun", RST_VC0_CTRL, vc0_ctrl);
    chk("snoop rerun", RST_ZERO, max_snoop_lat);
    chk("unc_mask rerun", RST_ZERO, unc_mask);
    i_rc.rd(OFF_PB_HDR, got);
    chk("pb next acs", {OFF_ACS_HDR, 4'h1, ID_PB}, got);
    i_rc.idle();
    wrap_up();
  end

endmodule : tb_pcie_extended_cap_space_map
